// >>> logic/hirq_map.svh
/*
 * register offsets, field positions and reset values of the host
 * interrupt enable and fifo level block.
 * assumes byte addresses on the host register bus, one 32-bit word each.
 */
`ifndef HIRQ_MAP_SVH
`define HIRQ_MAP_SVH

`define HIRQ_OFS_IRQ_ENABLE 12'h05c
`define HIRQ_OFS_FIFO_LEVEL 12'h068

// enable and status bit positions
`define HIRQ_BIT_SW_IRQ 31
`define HIRQ_BIT_READY 30
`define HIRQ_BIT_PTIME 29
`define HIRQ_BIT_SWITCH 28
`define HIRQ_BIT_PHY2 27
`define HIRQ_BIT_PHY1 26
`define HIRQ_BIT_TX_STOP 25
`define HIRQ_BIT_RX_STOP 24
`define HIRQ_BIT_DROP_HALF 23
`define HIRQ_BIT_TX_DONE 21
`define HIRQ_BIT_RX_DMA 20
`define HIRQ_BIT_GP_TIMER 19
`define HIRQ_BIT_POWER 17
`define HIRQ_BIT_TXS_OVFL 16
`define HIRQ_BIT_RX_WDOG 15
`define HIRQ_BIT_RX_ERR 14
`define HIRQ_BIT_TX_ERR 13
`define HIRQ_BIT_GPIO 12
`define HIRQ_BIT_TXD_OVERRUN 10
`define HIRQ_BIT_TXD_SPACE 9
`define HIRQ_BIT_TXS_FULL 8
`define HIRQ_BIT_TXS_LEVEL 7
`define HIRQ_BIT_RX_DROP 6
`define HIRQ_BIT_RXS_FULL 4
`define HIRQ_BIT_RXS_LEVEL 3

// writable enable bits: 22, 18 and 2:0 are read-only zero, 11 and 5 writable
`define HIRQ_ENABLE_WMASK 32'hffbb_fff8
`define HIRQ_ENABLE_RESET 32'h0000_0000
// status bits that exist; 11 and 5 have no source
`define HIRQ_STATUS_MASK 32'hffbb_f7d8

// fifo level field positions
`define HIRQ_TXD_LVL_MSB 31
`define HIRQ_TXD_LVL_LSB 24
`define HIRQ_TXS_LVL_MSB 23
`define HIRQ_TXS_LVL_LSB 16
`define HIRQ_RSVD_LVL_MSB 15
`define HIRQ_RSVD_LVL_LSB 8
`define HIRQ_RXS_LVL_MSB 7
`define HIRQ_RXS_LVL_LSB 0
`define HIRQ_FIFO_LEVEL_RESET 32'h4800_0000

`endif

// >>> logic/hirq_pkg.sv
/*
 * types of the host interrupt enable and fifo level block.
 * assumes the constants of hirq_map.svh for field positions.
 */
package hirq_pkg;

    // one host register access, taken in a single cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } hirq_req_t;

    // fifo fill levels reported by the fifo logic
    typedef struct packed {
        logic [7:0] tx_free_blocks;
        logic [7:0] tx_status_used;
        logic [7:0] rx_status_used;
    } hirq_levels_t;

    // fifo events from the fifo logic, one-cycle or level
    typedef struct packed {
        logic tx_data_write;
        logic tx_data_full;
        logic tx_status_full;
        logic rx_status_full;
    } hirq_fifo_ev_t;

endpackage

// >>> logic/hirq_top.sv
/*
 * host interrupt enable masking, interrupt status capture and fifo level
 * interrupt generation, with the two registers on the host register bus.
 * assumes all inputs come from logic on core_clk, so none is synchronised,
 * and that the owner of the status register drives status_clear.
 * the host sees a status bit one cycle after its event and the pin one
 * cycle after that; software that polls the pin must allow for both.
 * bits 11 and 5 of the enable register are stored and read back, but
 * they gate nothing, since no status source sits behind them.
 * the fifo level compares are strictly greater, so a threshold of ff
 * can never raise its flag; that is the price of an 8-bit field.
 * clk_en low freezes every register, so events in that time are lost.
 */
`timescale 1ns/1ps
`include "hirq_map.svh"

//Contract
//[R1] a status source reaches the interrupt pin only when its enable bit is 1.
//[R2] status bits follow their sources regardless of enables, except the software interrupt which needs its enable.
//[R3] enable bits 31..28 are software, device ready, precision time and switch engine.
//[R4] enable bits 27..23 are second phy, first phy, tx stopped, rx stopped and drop counter halfway.
//[R5] enable bits 21,20,19,17,16 are tx completion, rx dma, timer, power event, tx status overflow; 22 and 18 read zero.
//[R6] enable bits 15..12 are rx watchdog, receiver error, transmitter error and gpio event.
//[R7] enable bits 10,9,8,7,6,4,3 are the fifo overrun, space, full, level and drop sources.
//[R8] software writes zero to the writable reserved enable bits 11 and 5.
//[R9] tx data space status rises when free 64-byte blocks exceed bits 31:24, reset 48h.
//[R10] tx status level status rises when tx status words exceed bits 23:16, reset 00h.
//[R11] rx status level status rises when rx status words exceed bits 7:0, reset zero.
//[R12] software writes zero to fifo level bits 15:8.
//[R13] tx data overrun status sets on a write to a full tx data fifo.
//[R14] tx status full status sets whenever the tx status fifo is full.
//[R15] the interrupt pin is high exactly when status and enable share a set bit; here the pin is registered and follows one cycle later.
//[R16] every writable enable bit resets to zero.
module hirq_top #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire hirq_pkg::hirq_req_t host_req,
    output logic [31:0] host_rdata,
    input wire logic [31:0] source_events,
    input wire hirq_pkg::hirq_levels_t fifo_levels,
    input wire hirq_pkg::hirq_fifo_ev_t fifo_events,
    input wire logic [31:0] status_clear,
    output logic [31:0] interrupt_source_status,
    output logic host_irq
);
    import hirq_pkg::*;

    // the offsets need twelve address bits; refuse anything else at elaboration
    if (ADDR_W != 12) begin : g_addr_w_check
        $error("hirq_top: ADDR_W must be 12");
    end

    logic [31:0] enable_q, enable_d;
    logic [31:0] level_q, level_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] status_q, status_d;
    logic irq_q, irq_d;
    logic sel_enable, sel_level;
    logic [31:0] raise;
    logic [31:0] pending;

    // enable views, top group
    logic software_irq_enable;
    logic device_ready_enable;
    logic precision_time_event_enable;
    logic switch_event_enable;
    logic second_port_phy_event_enable;
    logic first_port_phy_event_enable;
    logic transmit_stopped_enable;
    logic receive_stopped_enable;
    logic drop_counter_halfway_enable;

    // enable views, middle group
    logic transmit_completion_enable;
    logic receive_dma_enable;
    logic general_timer_enable;
    logic power_event_enable;
    logic tx_status_overflow_enable;
    logic receive_watchdog_enable;
    logic receiver_error_enable;
    logic transmitter_error_enable;
    logic gpio_event_enable;

    // enable views, fifo group
    logic tx_data_overrun_enable;
    logic tx_data_space_enable;
    logic tx_status_full_enable;
    logic tx_status_level_enable;
    logic receive_dropped_frame_enable;
    logic rx_status_full_enable;
    logic rx_status_level_enable;

    // threshold fields of the level register
    logic [7:0] tx_space_threshold;
    logic [7:0] tx_status_threshold;
    logic [7:0] rx_status_threshold;

    // fifo flags computed here for five fifo status sources; rx status full has none and comes from fifo_events
    logic tx_data_space_flag;
    logic tx_status_level_flag;
    logic rx_status_level_flag;
    logic tx_data_overrun_flag;
    logic tx_status_full_flag;

    assign sel_enable = (host_req.addr == `HIRQ_OFS_IRQ_ENABLE);
    assign sel_level = (host_req.addr == `HIRQ_OFS_FIFO_LEVEL);

    // top group of enables
    assign software_irq_enable = enable_q[`HIRQ_BIT_SW_IRQ]; // [R3]
    assign device_ready_enable = enable_q[`HIRQ_BIT_READY]; // [R3]
    assign precision_time_event_enable = enable_q[`HIRQ_BIT_PTIME]; // [R3]
    assign switch_event_enable = enable_q[`HIRQ_BIT_SWITCH]; // [R3]
    assign second_port_phy_event_enable = enable_q[`HIRQ_BIT_PHY2]; // [R4]
    assign first_port_phy_event_enable = enable_q[`HIRQ_BIT_PHY1]; // [R4]
    assign transmit_stopped_enable = enable_q[`HIRQ_BIT_TX_STOP]; // [R4]
    assign receive_stopped_enable = enable_q[`HIRQ_BIT_RX_STOP]; // [R4]
    assign drop_counter_halfway_enable = enable_q[`HIRQ_BIT_DROP_HALF]; // [R4]

    // middle group of enables; 22 and 18 are never stored
    assign transmit_completion_enable = enable_q[`HIRQ_BIT_TX_DONE]; // [R5]
    assign receive_dma_enable = enable_q[`HIRQ_BIT_RX_DMA]; // [R5]
    assign general_timer_enable = enable_q[`HIRQ_BIT_GP_TIMER]; // [R5]
    assign power_event_enable = enable_q[`HIRQ_BIT_POWER]; // [R5]
    assign tx_status_overflow_enable = enable_q[`HIRQ_BIT_TXS_OVFL]; // [R5]
    assign receive_watchdog_enable = enable_q[`HIRQ_BIT_RX_WDOG]; // [R6]
    assign receiver_error_enable = enable_q[`HIRQ_BIT_RX_ERR]; // [R6]
    assign transmitter_error_enable = enable_q[`HIRQ_BIT_TX_ERR]; // [R6]
    assign gpio_event_enable = enable_q[`HIRQ_BIT_GPIO]; // [R6]

    // fifo group of enables
    assign tx_data_overrun_enable = enable_q[`HIRQ_BIT_TXD_OVERRUN]; // [R7]
    assign tx_data_space_enable = enable_q[`HIRQ_BIT_TXD_SPACE]; // [R7]
    assign tx_status_full_enable = enable_q[`HIRQ_BIT_TXS_FULL]; // [R7]
    assign tx_status_level_enable = enable_q[`HIRQ_BIT_TXS_LEVEL]; // [R7]
    assign receive_dropped_frame_enable = enable_q[`HIRQ_BIT_RX_DROP]; // [R7]
    assign rx_status_full_enable = enable_q[`HIRQ_BIT_RXS_FULL]; // [R7]
    assign rx_status_level_enable = enable_q[`HIRQ_BIT_RXS_LEVEL]; // [R7]

    // threshold fields
    assign tx_space_threshold = level_q[`HIRQ_TXD_LVL_MSB:`HIRQ_TXD_LVL_LSB]; // [R9]
    assign tx_status_threshold = level_q[`HIRQ_TXS_LVL_MSB:`HIRQ_TXS_LVL_LSB]; // [R10]
    assign rx_status_threshold = level_q[`HIRQ_RXS_LVL_MSB:`HIRQ_RXS_LVL_LSB]; // [R11]

    // level flags are strictly greater; event flags follow the fifo logic
    assign tx_data_space_flag = fifo_levels.tx_free_blocks > tx_space_threshold; // [R9]
    assign tx_status_level_flag = fifo_levels.tx_status_used > tx_status_threshold; // [R10]
    assign rx_status_level_flag = fifo_levels.rx_status_used > rx_status_threshold; // [R11]
    assign tx_data_overrun_flag = fifo_events.tx_data_write & fifo_events.tx_data_full; // [R13]
    assign tx_status_full_flag = fifo_events.tx_status_full; // [R14]

    // register writes and registered read data; unmapped reads give zero
    always_comb begin
        enable_d = enable_q;
        level_d = level_q;
        rdata_d = rdata_q;
        if (host_req.wr && sel_enable) begin
            // reserved read-only bits are not stored, 11 and 5 are kept as written
            enable_d = host_req.wdata & `HIRQ_ENABLE_WMASK; // [R3] [R4] [R5] [R6] [R7] [R8]
        end
        if (host_req.wr && sel_level) begin
            // every field stored as written, reserved 15:8 included
            level_d[`HIRQ_TXD_LVL_MSB:`HIRQ_TXD_LVL_LSB] = host_req.wdata[`HIRQ_TXD_LVL_MSB:`HIRQ_TXD_LVL_LSB];
            level_d[`HIRQ_TXS_LVL_MSB:`HIRQ_TXS_LVL_LSB] = host_req.wdata[`HIRQ_TXS_LVL_MSB:`HIRQ_TXS_LVL_LSB];
            level_d[`HIRQ_RSVD_LVL_MSB:`HIRQ_RSVD_LVL_LSB] = host_req.wdata[`HIRQ_RSVD_LVL_MSB:`HIRQ_RSVD_LVL_LSB]; // [R12]
            level_d[`HIRQ_RXS_LVL_MSB:`HIRQ_RXS_LVL_LSB] = host_req.wdata[`HIRQ_RXS_LVL_MSB:`HIRQ_RXS_LVL_LSB];
        end

        // a read in the same cycle as a write returns the old value
        if (host_req.rd) begin
            case (host_req.addr)
                `HIRQ_OFS_IRQ_ENABLE: begin
                    rdata_d = enable_q;
                end
                `HIRQ_OFS_FIFO_LEVEL: begin
                    rdata_d = level_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000; // unmapped reads give zero
                end
            endcase
        end
    end

    // register bank; reset ignores clk_en, everything else waits for it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_q <= `HIRQ_ENABLE_RESET; // [R16]
            level_q <= `HIRQ_FIFO_LEVEL_RESET; // [R9] [R10] [R11]
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            enable_q <= enable_d;
            level_q <= level_d;
            rdata_q <= rdata_d;
        end
    end

    // sources that set status bits this cycle
    always_comb begin
        // bits without a source stay zero, so reserved status never sets
        raise = 32'h0000_0000;

        // sources owned by other blocks pass straight through
        raise[`HIRQ_BIT_READY] = source_events[`HIRQ_BIT_READY];
        raise[`HIRQ_BIT_PTIME] = source_events[`HIRQ_BIT_PTIME];
        raise[`HIRQ_BIT_SWITCH] = source_events[`HIRQ_BIT_SWITCH];
        raise[`HIRQ_BIT_PHY2] = source_events[`HIRQ_BIT_PHY2];
        raise[`HIRQ_BIT_PHY1] = source_events[`HIRQ_BIT_PHY1];
        raise[`HIRQ_BIT_TX_STOP] = source_events[`HIRQ_BIT_TX_STOP];
        raise[`HIRQ_BIT_RX_STOP] = source_events[`HIRQ_BIT_RX_STOP];
        raise[`HIRQ_BIT_DROP_HALF] = source_events[`HIRQ_BIT_DROP_HALF];
        raise[`HIRQ_BIT_TX_DONE] = source_events[`HIRQ_BIT_TX_DONE];
        raise[`HIRQ_BIT_RX_DMA] = source_events[`HIRQ_BIT_RX_DMA];
        raise[`HIRQ_BIT_GP_TIMER] = source_events[`HIRQ_BIT_GP_TIMER];
        raise[`HIRQ_BIT_POWER] = source_events[`HIRQ_BIT_POWER];
        raise[`HIRQ_BIT_TXS_OVFL] = source_events[`HIRQ_BIT_TXS_OVFL];
        raise[`HIRQ_BIT_RX_WDOG] = source_events[`HIRQ_BIT_RX_WDOG];
        raise[`HIRQ_BIT_RX_ERR] = source_events[`HIRQ_BIT_RX_ERR];
        raise[`HIRQ_BIT_TX_ERR] = source_events[`HIRQ_BIT_TX_ERR];
        raise[`HIRQ_BIT_GPIO] = source_events[`HIRQ_BIT_GPIO];
        raise[`HIRQ_BIT_RX_DROP] = source_events[`HIRQ_BIT_RX_DROP];

        // software interrupt only exists while its enable is set
        raise[`HIRQ_BIT_SW_IRQ] = software_irq_enable; // [R2]

        // fifo sources come from the flags above, rx status full straight from fifo_events, not from source_events
        raise[`HIRQ_BIT_TXD_SPACE] = tx_data_space_flag; // [R9]
        raise[`HIRQ_BIT_TXS_LEVEL] = tx_status_level_flag; // [R10]
        raise[`HIRQ_BIT_RXS_LEVEL] = rx_status_level_flag; // [R11]
        raise[`HIRQ_BIT_TXD_OVERRUN] = tx_data_overrun_flag; // [R13]
        raise[`HIRQ_BIT_TXS_FULL] = tx_status_full_flag; // [R14]
        raise[`HIRQ_BIT_RXS_FULL] = fifo_events.rx_status_full;
    end

    // sticky status, set wins over clear so no event is lost;
    // the pin is registered, so it lags the status by one cycle
    always_comb begin
        // clear first, then set, so an event in the clearing cycle survives
        status_d = status_q & ~status_clear;
        status_d = (status_d | raise) & `HIRQ_STATUS_MASK; // [R2]
        if (!software_irq_enable) begin
            status_d[`HIRQ_BIT_SW_IRQ] = 1'b0; // [R2]
        end

        // each status bit reaches the pin only through its own enable
        pending = 32'h0000_0000;
        pending[`HIRQ_BIT_SW_IRQ] = status_q[`HIRQ_BIT_SW_IRQ] & software_irq_enable; // [R1]
        pending[`HIRQ_BIT_READY] = status_q[`HIRQ_BIT_READY] & device_ready_enable; // [R1]
        pending[`HIRQ_BIT_PTIME] = status_q[`HIRQ_BIT_PTIME] & precision_time_event_enable; // [R1]
        pending[`HIRQ_BIT_SWITCH] = status_q[`HIRQ_BIT_SWITCH] & switch_event_enable; // [R1]
        pending[`HIRQ_BIT_PHY2] = status_q[`HIRQ_BIT_PHY2] & second_port_phy_event_enable; // [R1]
        pending[`HIRQ_BIT_PHY1] = status_q[`HIRQ_BIT_PHY1] & first_port_phy_event_enable; // [R1]
        pending[`HIRQ_BIT_TX_STOP] = status_q[`HIRQ_BIT_TX_STOP] & transmit_stopped_enable; // [R1]
        pending[`HIRQ_BIT_RX_STOP] = status_q[`HIRQ_BIT_RX_STOP] & receive_stopped_enable; // [R1]
        pending[`HIRQ_BIT_DROP_HALF] = status_q[`HIRQ_BIT_DROP_HALF] & drop_counter_halfway_enable; // [R1]

        // middle group
        pending[`HIRQ_BIT_TX_DONE] = status_q[`HIRQ_BIT_TX_DONE] & transmit_completion_enable; // [R1]
        pending[`HIRQ_BIT_RX_DMA] = status_q[`HIRQ_BIT_RX_DMA] & receive_dma_enable; // [R1]
        pending[`HIRQ_BIT_GP_TIMER] = status_q[`HIRQ_BIT_GP_TIMER] & general_timer_enable; // [R1]
        pending[`HIRQ_BIT_POWER] = status_q[`HIRQ_BIT_POWER] & power_event_enable; // [R1]
        pending[`HIRQ_BIT_TXS_OVFL] = status_q[`HIRQ_BIT_TXS_OVFL] & tx_status_overflow_enable; // [R1]
        pending[`HIRQ_BIT_RX_WDOG] = status_q[`HIRQ_BIT_RX_WDOG] & receive_watchdog_enable; // [R1]
        pending[`HIRQ_BIT_RX_ERR] = status_q[`HIRQ_BIT_RX_ERR] & receiver_error_enable; // [R1]
        pending[`HIRQ_BIT_TX_ERR] = status_q[`HIRQ_BIT_TX_ERR] & transmitter_error_enable; // [R1]
        pending[`HIRQ_BIT_GPIO] = status_q[`HIRQ_BIT_GPIO] & gpio_event_enable; // [R1]

        // fifo group
        pending[`HIRQ_BIT_TXD_OVERRUN] = status_q[`HIRQ_BIT_TXD_OVERRUN] & tx_data_overrun_enable; // [R1]
        pending[`HIRQ_BIT_TXD_SPACE] = status_q[`HIRQ_BIT_TXD_SPACE] & tx_data_space_enable; // [R1]
        pending[`HIRQ_BIT_TXS_FULL] = status_q[`HIRQ_BIT_TXS_FULL] & tx_status_full_enable; // [R1]
        pending[`HIRQ_BIT_TXS_LEVEL] = status_q[`HIRQ_BIT_TXS_LEVEL] & tx_status_level_enable; // [R1]
        pending[`HIRQ_BIT_RX_DROP] = status_q[`HIRQ_BIT_RX_DROP] & receive_dropped_frame_enable; // [R1]
        pending[`HIRQ_BIT_RXS_FULL] = status_q[`HIRQ_BIT_RXS_FULL] & rx_status_full_enable; // [R1]
        pending[`HIRQ_BIT_RXS_LEVEL] = status_q[`HIRQ_BIT_RXS_LEVEL] & rx_status_level_enable; // [R1]
        irq_d = |pending; // [R15]
    end

    // status and pin registers, frozen with the rest while clk_en is low
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    assign host_rdata = rdata_q;
    assign interrupt_source_status = status_q;
    assign host_irq = irq_q;

endmodule // hirq_top

// >>> verification/hirq_host_model.sv
/* host cpu model: one register access per call.
   assumes core_clk comes from the bench. */
`timescale 1ns/1ps
module hirq_host_model (
    input wire logic core_clk,
    output hirq_pkg::hirq_req_t host_req
);
    initial host_req = '0;
    // writable reserved bits (enable 11 and 5, level 15:8) masked to zero so callers may pass any pattern
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk) #10;
        host_req = '{w, !w, a, a == 12'h05c ? d & 32'hfffff7df : a == 12'h068 ? d & 32'hffff00ff : d};
        @(posedge core_clk) #10;
        host_req = '0;
    endtask
endmodule // hirq_host_model

// >>> verification/hirq_top_properties.sv
/* checker of hirq_top on its ports.
   assumes nothing is checked while clk_en is low. */
`timescale 1ns/1ps
module hirq_top_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire hirq_pkg::hirq_req_t host_req,
    input wire logic [31:0] host_rdata,
    input wire hirq_pkg::hirq_levels_t fifo_levels,
    input wire hirq_pkg::hirq_fifo_ev_t fifo_events,
    input wire logic [31:0] status_clear,
    input wire logic [31:0] interrupt_source_status,
    input wire logic host_irq
);
    logic [31:0] lvl_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    // shadow of the level register, the pin view has no other copy
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst) lvl_q <= 32'h4800_0000;
        else if (clk_en && host_req.wr && host_req.addr == 12'h068) lvl_q <= host_req.wdata;
    sequence s_unmapped_rd;
        host_req.rd && host_req.addr != 12'h05c && host_req.addr != 12'h068;
    endsequence
    a_irq_has_cause: assert property (host_irq |-> $past(interrupt_source_status) != 0) else $error("irq no cause");
    a_irq_low_idle: assert property (interrupt_source_status == 32'h0 |=> !host_irq) else $error("irq no status");
    a_space_flag: assert property (fifo_levels.tx_free_blocks > lvl_q[31:24] |=> interrupt_source_status[9]) else $error("space");
    a_txs_level: assert property (fifo_levels.tx_status_used > lvl_q[23:16] |=> interrupt_source_status[7]) else $error("txs");
    a_rxs_level: assert property (fifo_levels.rx_status_used > lvl_q[7:0] |=> interrupt_source_status[3]) else $error("rxs");
    a_overrun_set: assert property (fifo_events.tx_data_write && fifo_events.tx_data_full |=> interrupt_source_status[10]) else $error("ovr");
    a_full_set: assert property (fifo_events.tx_status_full |=> interrupt_source_status[8]) else $error("full");
    a_rx_full_set: assert property (fifo_events.rx_status_full |=> interrupt_source_status[4]) else $error("rx full");
    a_sticky_ready: assert property (interrupt_source_status[30] && !status_clear[30] |=> interrupt_source_status[30]) else $error("sticky");
    a_unmapped_zero: assert property (s_unmapped_rd |=> host_rdata == 32'h0) else $error("unmapped");
    a_reserved_zero: assert property (host_req.rd && host_req.addr == 12'h05c |=> (host_rdata & 32'h0044_0007) == 0) else $error("rsvd");
endmodule // hirq_top_checker
bind hirq_top hirq_top_checker hirq_top_checker_inst (.*);

// >>> verification/tb_hirq_top.sv
/* self-checking bench of hirq_top through the host cpu model.
   assumes the design files compile first. */
`timescale 1ns/1ps
module tb_hirq_top;
    logic core_clk, sys_rst, clk_en, host_irq;
    hirq_pkg::hirq_req_t host_req;
    logic [31:0] host_rdata, source_events, status_clear, sts;
    hirq_pkg::hirq_levels_t fifo_levels;
    hirq_pkg::hirq_fifo_ev_t fifo_events;
    int n_fail = 0;
    int n_checks = 0;
    hirq_host_model hirq_host_model_inst (.core_clk(core_clk), .host_req(host_req));
    hirq_top hirq_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .host_req(host_req),
        .host_rdata(host_rdata), .source_events(source_events), .fifo_levels(fifo_levels),
        .fifo_events(fifo_events), .status_clear(status_clear), .interrupt_source_status(sts), .host_irq(host_irq));
    initial begin
        core_clk = 0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        hirq_host_model_inst.acc(1'b0, a, 32'h0);
        chk(host_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask
    task automatic results();
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // hang guard at 1000 cycles, far beyond the 58 or so cycles of the tests
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        sys_rst = 1;
        clk_en = 1;
        source_events = '0;
        status_clear = '0;
        fifo_levels = '0;
        fifo_events = '0;
        cyc(5);
        sys_rst = 0;
        rd(12'h05c, 32'h0);
        rd(12'h068, 32'h4800_0000);
        rd(12'h060, 32'h0);
        source_events[30] = 1;
        cyc(1);
        source_events = '0;
        cyc(2);
        chk(sts, 32'h4000_0000);
        chk(host_irq, 0);
        hirq_host_model_inst.acc(1'b1, 12'h05c, 32'hffff_ffff);
        rd(12'h05c, 32'hffbb_f7d8);
        cyc(1);
        chk(sts, 32'hc000_0000);
        chk(host_irq, 1);
        hirq_host_model_inst.acc(1'b1, 12'h05c, 32'h0);
        cyc(2);
        chk(sts, 32'h4000_0000);
        chk(host_irq, 0);
        hirq_host_model_inst.acc(1'b1, 12'h068, 32'h1005_ff03);
        rd(12'h068, 32'h1005_0003);
        fifo_levels = '{8'h10, 8'h05, 8'h03};
        status_clear = '1;
        cyc(2);
        status_clear = '0;
        cyc(2);
        chk(sts, 32'h0);
        fifo_levels = '{8'h11, 8'h06, 8'h04};
        cyc(2);
        chk(sts, 32'h0000_0288);
        fifo_levels = '0;
        status_clear = '1;
        cyc(2);
        status_clear = '0;
        fifo_events = '1;
        cyc(1);
        fifo_events = '0;
        cyc(1);
        chk(sts, 32'h0000_0510);
        // per-source gating: only the gpio event is enabled
        status_clear = '1;
        cyc(1);
        status_clear = '0;
        hirq_host_model_inst.acc(1'b1, 12'h05c, 32'h0000_1000);
        source_events[13] = 1;
        cyc(1);
        source_events = '0;
        cyc(2);
        chk(sts, 32'h0000_2000);
        chk(host_irq, 0);
        source_events[12] = 1;
        cyc(1);
        source_events = '0;
        cyc(2);
        chk(sts, 32'h0000_3000);
        chk(host_irq, 1);
        status_clear = 32'h0000_1000;
        cyc(1);
        status_clear = '0;
        cyc(2);
        chk(sts, 32'h0000_2000);
        chk(host_irq, 0);
        // clk_en low freezes the block, so this event is never seen
        clk_en = 0;
        source_events[14] = 1;
        cyc(2);
        source_events = '0;
        clk_en = 1;
        cyc(1);
        chk(sts, 32'h0000_2000);
        // second reset in mid-run
        sys_rst = 1;
        cyc(2);
        chk(sts, 32'h0);
        chk(host_irq, 0);
        sys_rst = 0;
        rd(12'h05c, 32'h0);
        rd(12'h068, 32'h4800_0000);
        results();
    end
endmodule // tb_hirq_top
